// [hdl/pdct_pkg.sv]
package pdct_pkg;
   localparam logic [4:0] OFF_CONTROL = 5'h10;
   localparam logic [4:0] OFF_VECTOR = 5'h11;
   localparam logic [4:0] OFF_PRE_PAD = 5'h12;
   localparam logic [4:0] OFF_PRE_HIGH = 5'h13;
   localparam logic [4:0] OFF_PRE_MID = 5'h14;
   localparam logic [4:0] OFF_PRE_LOW = 5'h15;
   localparam logic [4:0] OFF_CNT_PAD = 5'h16;
   localparam logic [4:0] OFF_CNT_HIGH = 5'h17;
   localparam logic [4:0] OFF_CNT_MID = 5'h18;
   localparam logic [4:0] OFF_CNT_LOW = 5'h19;
   localparam logic [4:0] OFF_FLAGS = 5'h1A;
   localparam logic [7:0] VECTOR_RESET = 8'h0F;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [4:0] PRESC_TOP = 5'h1F;
   localparam logic [4:0] PRESC_BOTTOM = 5'h00;
   localparam logic [23:0] COUNT_ONE = 24'h000001;
   localparam logic [23:0] COUNT_ZERO = 24'h000000;
   // control field positions and synchroniser depth
   localparam int CTL_ENABLE = 0;
   localparam int CTL_CLK_LO = 1;
   localparam int CTL_ZD = 4;
   localparam int CTL_PIN_LO = 5;
   localparam int CTL_UNUSED = 3;
   localparam int SYNC_STAGES = 3;

   typedef enum logic [1:0] {CLK_SYS, CLK_GATED, CLK_TIN_PRE, CLK_TIN_DIRECT} pdct_clk_type;
   typedef enum logic {BUS_IDLE, BUS_ACK} pdct_bus_type;

   typedef struct packed {
      logic csN;
      logic readNotWrite;
      logic [4:0] regSel;
      logic [7:0] data;
   } pdct_bus_req_type;

   typedef struct packed {
      logic [7:0] data;
      logic dataOe;
      logic dtackN;
      logic dtackOe;
   } pdct_bus_rsp_type;

   typedef struct packed {
      pdct_bus_type bus;
      logic readCycle;
      logic [7:0] dataOut;
      logic [7:0] control;
      logic [7:0] vector;
      logic [23:0] preload;
      logic [23:0] count;
      logic [4:0] presc;
      logic needLoad;
      logic zeroFlag;
      logic square;
      logic [SYNC_STAGES-1:0] tinSync;
   } pdct_state_type;
endpackage : pdct_pkg

// [hdl/pdct_timer.sv]
`timescale 1ns/1ps
module pdct_timer import pdct_pkg::*; (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // register bus
   input wire pdct_bus_req_type busReq,
   output pdct_bus_rsp_type busRsp,
   // timer pins
   input wire logic dualPinIn,
   input wire logic dualPinAckN,
   output logic timerOutPin,
   output logic timerOutOe
);
   pdct_state_type st_reg;
   pdct_state_type st_next;
   pdct_clk_type clkMode;
   logic [2:0] pinMode;
   logic tinLevel;
   logic tinRise;
   logic runState;
   logic prescUsed;
   logic prescStep;
   logic tick;
   logic zeroEvent;
   logic flagWriteOne;
   logic irqActive;
   logic ackFunction;
   logic busTake;
   logic ackTake;

   // read data mux; count is live, never latched
   function automatic logic [7:0] readMux(input pdct_state_type s, input logic [4:0] sel);
      logic [7:0] r;
      r = 8'h00;
      case (sel)
         OFF_CONTROL: r = s.control & ~(8'h01 << CTL_UNUSED);
         OFF_VECTOR: r = s.vector;
         OFF_PRE_HIGH: r = s.preload[23:16];
         OFF_PRE_MID: r = s.preload[15:8];
         OFF_PRE_LOW: r = s.preload[7:0];
         OFF_CNT_HIGH: r = s.count[23:16];
         OFF_CNT_MID: r = s.count[15:8];
         OFF_CNT_LOW: r = s.count[7:0];
         OFF_FLAGS: r = {7'h00, s.zeroFlag};
         default: r = 8'h00;
      endcase
      return r;
   endfunction : readMux

   // vectored configuration is the only one that answers an acknowledge
   function automatic logic isVectored(input logic [2:0] m);
      return m == 3'b101;
   endfunction : isVectored

   assign clkMode = pdct_clk_type'(st_reg.control[CTL_CLK_LO +: 2]);
   assign pinMode = st_reg.control[CTL_PIN_LO +: 3];
   // only the second and third stages are looked at
   assign tinLevel = st_reg.tinSync[1];
   assign tinRise = st_reg.tinSync[1] & ~st_reg.tinSync[2];

   always_comb begin
      runState = st_reg.control[CTL_ENABLE];
      if (clkMode == CLK_GATED) begin
         runState = st_reg.control[CTL_ENABLE] & tinLevel;
      end
   end

   assign prescUsed = (clkMode != CLK_TIN_DIRECT);
   // the prescaler follows mclk except in the two input-driven modes
   assign prescStep = runState & prescUsed & ((clkMode == CLK_TIN_PRE) ? tinRise : 1'b1);
   // the counter is ticked by prescaler rollover or a direct input edge
   assign tick = runState & (prescUsed ? (prescStep & (st_reg.presc == PRESC_BOTTOM)) :
                 tinRise);
   assign zeroEvent = tick & ~st_reg.needLoad & (st_reg.count == COUNT_ONE);
   assign busTake = (st_reg.bus == BUS_IDLE) & ~busReq.csN;
   assign flagWriteOne = busTake & ~busReq.readNotWrite & (busReq.regSel == OFF_FLAGS) &
                         busReq.data[0];
   assign ackFunction = (pinMode[2:1] == 2'b10) | (pinMode == 3'b110);
   assign irqActive = pinMode[2] & pinMode[0] & st_reg.zeroFlag;
   // acknowledge with the vector only from the vectored configuration
   assign ackTake = (st_reg.bus == BUS_IDLE) & busReq.csN & ~dualPinAckN &
                    isVectored(pinMode) & st_reg.zeroFlag;

   always_comb begin
      st_next = st_reg;
      st_next.tinSync = {st_reg.tinSync[SYNC_STAGES-2:0], dualPinIn};

      // prescaler: halt parks it at the top value
      if (!runState) begin
         st_next.presc = PRESC_TOP;
         st_next.needLoad = 1'b1;
      end else if (prescStep) begin
         st_next.presc = st_reg.presc - 5'h01;
      end

      // counter: first tick after run loads, later ones count or reload
      if (tick) begin
         if (st_reg.needLoad) begin
            st_next.count = st_reg.preload;
            st_next.needLoad = 1'b0;
         end else if (st_reg.count == COUNT_ZERO && !st_reg.control[CTL_ZD]) begin
            st_next.count = st_reg.preload;
         end else begin
            st_next.count = st_reg.count - COUNT_ONE;
         end
      end

      // flag: clear dominates set
      if (zeroEvent) begin
         st_next.zeroFlag = 1'b1;
      end
      if (flagWriteOne || !runState) begin
         st_next.zeroFlag = 1'b0;
      end

      // square wave idles high while halted
      if (!runState) begin
         st_next.square = 1'b1;
      end else if (zeroEvent) begin
         st_next.square = ~st_reg.square;
      end

      // bus: one access per select, acknowledge held until select and the acknowledge input are both released
      case (st_reg.bus)
         BUS_IDLE: begin
            if (busTake) begin
               st_next.bus = BUS_ACK;
               st_next.readCycle = busReq.readNotWrite;
               st_next.dataOut = readMux(st_reg, busReq.regSel);
               if (!busReq.readNotWrite) begin
                  case (busReq.regSel)
                     OFF_CONTROL: st_next.control = busReq.data & ~(8'h01 << CTL_UNUSED);
                     OFF_VECTOR: st_next.vector = busReq.data;
                     OFF_PRE_HIGH: st_next.preload[23:16] = busReq.data;
                     OFF_PRE_MID: st_next.preload[15:8] = busReq.data;
                     OFF_PRE_LOW: st_next.preload[7:0] = busReq.data;
                     // count and pad addresses drop the data; flag writes act through flagWriteOne
                     default: st_next.control = st_reg.control;
                  endcase
               end
            end else if (ackTake) begin
               st_next.bus = BUS_ACK;
               st_next.readCycle = 1'b1;
               st_next.dataOut = st_reg.vector;
            end
         end
         BUS_ACK: begin
            if (busReq.csN && dualPinAckN) begin
               st_next.bus = BUS_IDLE;
               st_next.readCycle = 1'b0;
            end
         end
         default: st_next.bus = BUS_IDLE;
      endcase
   end

   // preload and count keep their value through reset
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg.bus <= BUS_IDLE;
         st_reg.readCycle <= 1'b0;
         st_reg.dataOut <= 8'h00;
         st_reg.control <= CONTROL_RESET;
         st_reg.vector <= VECTOR_RESET;
         st_reg.presc <= PRESC_TOP;
         st_reg.needLoad <= 1'b1;
         st_reg.zeroFlag <= 1'b0;
         st_reg.square <= 1'b1;
         st_reg.tinSync <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   always_comb begin
      busRsp.data = st_reg.dataOut;
      busRsp.dataOe = (st_reg.bus == BUS_ACK) & st_reg.readCycle;
      busRsp.dtackN = ~(st_reg.bus == BUS_ACK);
      busRsp.dtackOe = (st_reg.bus == BUS_ACK);
   end

   // open-drain request low while the flag stands; square mode drives both levels
   always_comb begin
      timerOutPin = 1'b0;
      timerOutOe = 1'b0;
      if (pinMode[2:1] == 2'b01) begin
         timerOutPin = st_reg.square;
         timerOutOe = 1'b1;
      end else if (irqActive) begin
         timerOutOe = 1'b1;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_ack_vector: assert property (ackTake |=> busRsp.dataOe && !busRsp.dtackN &&
      busRsp.data == $past(st_reg.vector))
      else $error("acknowledge did not return the vector");
   a_ack_refused: assert property ((st_reg.bus == BUS_IDLE) && busReq.csN && !dualPinAckN &&
      !(pinMode == 3'b101 && st_reg.zeroFlag) |=> busRsp.dtackN)
      else $error("acknowledge answered without a request");
   a_pad_zero: assert property (busTake && busReq.readNotWrite &&
      busReq.regSel == OFF_PRE_PAD |=> busRsp.data == 8'h00)
      else $error("pad address read nonzero");
   a_flags_upper: assert property (busTake && busReq.readNotWrite &&
      busReq.regSel == OFF_FLAGS |=> busRsp.data[7:1] == 7'h00)
      else $error("flags upper bits nonzero");
   a_zero_sets: assert property (zeroEvent && runState && !flagWriteOne
      |=> st_reg.zeroFlag && st_reg.count == COUNT_ZERO)
      else $error("zero event did not set the flag");
   a_clear_wins: assert property (flagWriteOne || !runState |=> !st_reg.zeroFlag)
      else $error("flag survived a clear");
   a_halt_hold: assert property (!runState ##1 !runState
      |-> st_reg.presc == PRESC_TOP && $stable(st_reg.count))
      else $error("halt did not freeze timer");
   a_first_load: assert property (tick && st_reg.needLoad
      |=> st_reg.count == $past(st_reg.preload) && !st_reg.needLoad)
      else $error("first tick did not load preload");
   a_reload_zero: assert property (tick && !st_reg.needLoad &&
      st_reg.count == COUNT_ZERO && !st_reg.control[CTL_ZD]
      |=> st_reg.count == $past(st_reg.preload))
      else $error("no reload after zero");
   a_irq_pin: assert property (pinMode[2] && pinMode[0] && st_reg.zeroFlag
      |-> timerOutOe && !timerOutPin)
      else $error("request pin not low");
   a_cnt_write: assert property (busTake && !busReq.readNotWrite &&
      busReq.regSel == OFF_CNT_LOW && !tick |=> !busRsp.dtackN &&
      st_reg.count == $past(st_reg.count))
      else $error("count write not dropped");

   a_vector_read: assert property (busTake && busReq.readNotWrite &&
      busReq.regSel == OFF_VECTOR |=> busRsp.data == $past(st_reg.vector))
      else $error("vector read wrong");

   a_vector_write: assert property (busTake && !busReq.readNotWrite &&
      busReq.regSel == OFF_VECTOR |=> st_reg.vector == $past(busReq.data))
      else $error("vector write lost");

   a_preload_low: assert property (busTake && !busReq.readNotWrite &&
      busReq.regSel == OFF_PRE_LOW |=> st_reg.preload[7:0] == $past(busReq.data))
      else $error("preload low write lost");

   a_preload_mid: assert property (busTake && !busReq.readNotWrite &&
      busReq.regSel == OFF_PRE_MID |=> st_reg.preload[15:8] == $past(busReq.data))
      else $error("preload mid write lost");

   a_preload_high: assert property (busTake && busReq.readNotWrite &&
      busReq.regSel == OFF_PRE_HIGH |=> busRsp.data == $past(st_reg.preload[23:16]))
      else $error("preload high read wrong");

   a_pad_write: assert property (busTake && !busReq.readNotWrite &&
      busReq.regSel == OFF_PRE_PAD |=> $stable(st_reg.preload) && $stable(st_reg.vector))
      else $error("pad write changed a register");

   a_count_mid: assert property (busTake && busReq.readNotWrite &&
      busReq.regSel == OFF_CNT_MID |=> busRsp.data == $past(st_reg.count[15:8]))
      else $error("count mid read wrong");

   a_count_high: assert property (busTake && busReq.readNotWrite &&
      busReq.regSel == OFF_CNT_HIGH |=> busRsp.data == $past(st_reg.count[23:16]))
      else $error("count high read wrong");

   a_bus_ack: assert property (busTake
      |=> !busRsp.dtackN && busRsp.dtackOe)
      else $error("access not acknowledged");

   a_flag_read: assert property (busTake && busReq.readNotWrite &&
      busReq.regSel == OFF_FLAGS |=> busRsp.data[0] == $past(st_reg.zeroFlag))
      else $error("flag read wrong");

   a_zero_write: assert property (busTake && !busReq.readNotWrite &&
      busReq.regSel == OFF_FLAGS && !busReq.data[0] && st_reg.zeroFlag && runState |=> st_reg.zeroFlag)
      else $error("zero write cleared the flag");

   a_count_step: assert property (tick && !st_reg.needLoad &&
      st_reg.count != COUNT_ZERO |=> st_reg.count == $past(st_reg.count) - COUNT_ONE)
      else $error("counter did not step down");

   a_rollover: assert property (tick && !st_reg.needLoad &&
      st_reg.count == COUNT_ZERO && st_reg.control[CTL_ZD] |=> st_reg.count == '1)
      else $error("counter did not roll over");

   a_presc_step: assert property (prescStep
      |=> st_reg.presc == $past(st_reg.presc) - 5'h01)
      else $error("prescaler did not step");

   a_tick_bottom: assert property (tick && prescUsed
      |-> st_reg.presc == PRESC_BOTTOM)
      else $error("tick without prescaler rollover");

   a_direct_tick: assert property (runState && clkMode == CLK_TIN_DIRECT
      |-> tick == tinRise)
      else $error("direct tick not on input edge");

   a_gated_halt: assert property (clkMode == CLK_GATED && !tinLevel
      |-> !runState)
      else $error("gated mode ran with input low");

   a_enable_off: assert property (!st_reg.control[CTL_ENABLE]
      |-> !runState)
      else $error("ran while disabled");

   a_enable_on: assert property (st_reg.control[CTL_ENABLE] && clkMode != CLK_GATED
      |-> runState)
      else $error("halted while enabled");

   a_sys_presc: assert property (runState &&
      (clkMode == CLK_SYS || clkMode == CLK_GATED) |-> prescStep)
      else $error("clock mode did not step prescaler");

   a_tin_presc: assert property (clkMode == CLK_TIN_PRE && !tinRise
      |-> !prescStep)
      else $error("prescaler stepped without input edge");

   a_sync_edge: assert property (tinRise
      |-> $past(dualPinIn, 2))
      else $error("edge seen before synchroniser");

   a_halt_presc: assert property (!runState
      |=> st_reg.presc == PRESC_TOP)
      else $error("prescaler not parked in halt");

   a_pins_free: assert property (pinMode[2:1] == 2'b00
      |-> !timerOutOe)
      else $error("pin driven in port mode");

   a_ack_mode: assert property (ackTake
      |-> ackFunction && isVectored(pinMode) && irqActive)
      else $error("acknowledge taken outside vectored mode");

   a_irq_off: assert property (pinMode == 3'b100 || pinMode == 3'b110
      |-> !timerOutOe)
      else $error("disabled request pin driven");

   a_irq_release: assert property (pinMode[2] && !st_reg.zeroFlag
      |-> !timerOutOe)
      else $error("request pin driven without flag");

   a_irq_low: assert property (timerOutOe && pinMode[2]
      |-> !timerOutPin)
      else $error("request pin driven high");

   c_zero_event: cover property (zeroEvent);
   c_ack_answered: cover property (ackTake ##1 !busRsp.dtackN);
   c_reload: cover property (tick && st_reg.count == COUNT_ZERO && !st_reg.needLoad);
   c_direct_tick: cover property (clkMode == CLK_TIN_DIRECT && tick);
   c_rollover: cover property (tick && st_reg.count == COUNT_ZERO && st_reg.control[CTL_ZD]);
endmodule : pdct_timer

// [tb/pdct_host_model.sv]
`timescale 1ns/1ps
module pdct_host_model import pdct_pkg::*; (
   // clock
   input wire logic mclk,
   // processor bus side
   output pdct_bus_req_type busReq,
   output logic ackN,
   input wire pdct_bus_rsp_type busRsp
);
   initial begin
      busReq = '{1'b1, 1'b1, 5'h00, 8'h00};
      ackN = 1'b1;
   end
   // request held until acknowledge is sampled; ok stays low when none comes
   task automatic cycle(input logic iack, input logic rdn, input logic [4:0] sel,
         input logic [7:0] wd, output logic [7:0] rdat, output logic ok);
      ok = 1'b0;
      rdat = 8'h00;
      @(negedge mclk);
      if (iack)
         ackN = 1'b0;
      else
         busReq = '{1'b0, rdn, sel, rdn ? ~busReq.data : wd};
      // sampled between edges, so the value is the one the next rising edge sees
      for (int i = 0; i < 40 && ok === 1'b0; i++) begin
         @(negedge mclk);
         ok = busRsp.dtackOe & ~busRsp.dtackN;
         rdat = busRsp.data;
      end
      if (ok === 1'b1)
         @(posedge mclk);
      @(negedge mclk);
      ackN = 1'b1;
      busReq.csN = 1'b1;
      // released data lines do not keep the last value
      busReq.data = ~busReq.data;
      repeat (3) @(posedge mclk);
   endtask : cycle
endmodule : pdct_host_model

// [tb/tb_prescaled_down_counter_timer.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin nChecks++; if ((a) !== (b)) begin failCount++; \
   $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module tb_prescaled_down_counter_timer import pdct_pkg::*; ;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic dualPinIn = 1'b0;
   logic ackN;
   pdct_bus_req_type busReq;
   pdct_bus_rsp_type busRsp;
   logic timerOutPin;
   logic timerOutOe;
   int failCount = 0;
   int nChecks = 0;
   int cycles = 0;
   logic [7:0] rd;
   logic ok;

   always #10 mclk = ~mclk;

   pdct_host_model host (.mclk(mclk), .busReq(busReq), .ackN(ackN), .busRsp(busRsp));
   pdct_timer dut (.mclk(mclk), .rst_n(rst_n), .busReq(busReq), .busRsp(busRsp),
      .dualPinIn(dualPinIn), .dualPinAckN(ackN), .timerOutPin(timerOutPin),
      .timerOutOe(timerOutOe));

   // whole run needs well under 20000 cycles
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         failCount++;
         finishTest();
      end
   end

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      host.cycle(1'b0, 1'b0, a, d, rd, ok);
      `CHK(ok, 1'b1)
   endtask : wr

   task automatic rdchk(input logic [4:0] a, input logic [7:0] e);
      host.cycle(1'b0, 1'b1, a, 8'h00, rd, ok);
      `CHK({ok, rd}, {1'b1, e})
   endtask : rdchk

   task automatic test_reset_values;
      rdchk(OFF_VECTOR, VECTOR_RESET);
      rdchk(OFF_CONTROL, CONTROL_RESET);
      rdchk(OFF_FLAGS, 8'h00);
      `CHK(timerOutOe, 1'b0)
   endtask : test_reset_values

   task automatic test_registers;
      wr(OFF_VECTOR, 8'h5A);
      rdchk(OFF_VECTOR, 8'h5A);
      wr(OFF_PRE_PAD, 8'hFF);
      rdchk(OFF_PRE_PAD, 8'h00);
      wr(OFF_PRE_HIGH, 8'hA5);
      wr(OFF_PRE_MID, 8'h3C);
      wr(OFF_PRE_LOW, 8'h96);
      rdchk(OFF_PRE_HIGH, 8'hA5);
      rdchk(OFF_PRE_MID, 8'h3C);
      rdchk(OFF_PRE_LOW, 8'h96);
      wr(OFF_CNT_PAD, 8'hFF);
      rdchk(OFF_CNT_PAD, 8'h00);
   endtask : test_registers

   task automatic test_interrupt;
      wr(OFF_PRE_HIGH, 8'h00);
      wr(OFF_PRE_MID, 8'h00);
      wr(OFF_PRE_LOW, 8'h02);
      // prescaled clock gives one tick per 32 clocks, inside the one-eighth limit
      wr(OFF_CONTROL, 8'hA1);
      for (int i = 0; i < 200 && timerOutOe !== 1'b1; i++) @(negedge mclk);
      `CHK({timerOutOe, timerOutPin}, 2'b10)
      rdchk(OFF_FLAGS, 8'h01);
      wr(OFF_FLAGS, 8'h00);
      rdchk(OFF_FLAGS, 8'h01);
      host.cycle(1'b1, 1'b1, 5'h00, 8'h00, rd, ok);
      `CHK({ok, rd}, 9'h15A)
      wr(OFF_FLAGS, 8'h01);
      rdchk(OFF_FLAGS, 8'h00);
      // halt next, so a fresh zero event cannot answer the refused acknowledge
      wr(OFF_CONTROL, 8'hA0);
      rdchk(OFF_FLAGS, 8'h00);
      host.cycle(1'b1, 1'b1, 5'h00, 8'h00, rd, ok);
      `CHK(ok, 1'b0)
   endtask : test_interrupt

   task automatic test_direct;
      wr(OFF_PRE_LOW, 8'h03);
      wr(OFF_CONTROL, 8'h07);
      repeat (2) begin
         // thirteen clocks per input period keeps the rate under one eighth
         @(negedge mclk) dualPinIn = 1'b1;
         repeat (6) @(negedge mclk);
         dualPinIn = 1'b0;
         repeat (6) @(negedge mclk);
      end
      wr(OFF_CONTROL, 8'h06);
      rdchk(OFF_CNT_HIGH, 8'h00);
      rdchk(OFF_CNT_MID, 8'h00);
      rdchk(OFF_CNT_LOW, 8'h02);
      repeat (40) @(negedge mclk);
      rdchk(OFF_CNT_LOW, 8'h02);
      @(negedge mclk) rst_n = 1'b0;
      repeat (2) @(negedge mclk);
      rst_n = 1'b1;
      rdchk(OFF_CNT_LOW, 8'h02);
      rdchk(OFF_PRE_LOW, 8'h03);
      rdchk(OFF_VECTOR, VECTOR_RESET);
      rdchk(OFF_CONTROL, CONTROL_RESET);
   endtask : test_direct

   task automatic pulses(input int n);
      repeat (n) begin
         @(negedge mclk) dualPinIn = 1'b1;
         repeat (3) @(negedge mclk);
         dualPinIn = 1'b0;
         repeat (4) @(negedge mclk);
      end
   endtask : pulses

   task automatic test_square;
      wr(OFF_PRE_LOW, 8'h01);
      wr(OFF_CONTROL, 8'h52);
      @(negedge mclk);
      `CHK({timerOutOe, timerOutPin}, 2'b11)
      dualPinIn = 1'b1;
      wr(OFF_CONTROL, 8'h53);
      for (int i = 0; i < 200 && timerOutPin !== 1'b0; i++) @(negedge mclk);
      `CHK({timerOutOe, timerOutPin}, 2'b10)
      rdchk(OFF_FLAGS, 8'h01);
      repeat (40) @(negedge mclk);
      dualPinIn = 1'b0;
      repeat (6) @(negedge mclk);
      rdchk(OFF_FLAGS, 8'h00);
      rdchk(OFF_CNT_HIGH, 8'hFF);
      @(negedge mclk);
      `CHK({timerOutOe, timerOutPin}, 2'b11)
   endtask : test_square

   task automatic test_tin_prescaled;
      wr(OFF_CONTROL, 8'h05);
      pulses(63);
      repeat (6) @(negedge mclk);
      rdchk(OFF_FLAGS, 8'h00);
      pulses(1);
      repeat (6) @(negedge mclk);
      rdchk(OFF_FLAGS, 8'h01);
      wr(OFF_CONTROL, 8'h04);
   endtask : test_tin_prescaled

   task automatic finishTest;
      $display("checks %0d mismatches %0d", nChecks, failCount);
      if (failCount == 0 && nChecks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : finishTest

   initial begin
      repeat (4) @(negedge mclk);
      rst_n = 1'b1;
      test_reset_values();
      test_registers();
      test_interrupt();
      test_square();
      test_tin_prescaled();
      test_direct();
      finishTest();
   end
endmodule : tb_prescaled_down_counter_timer
